// file: gdsp_pkg.sv
package gdsp_pkg;
  // register byte offsets
  localparam logic [7:0] GDSP_SUPPLY_CFG_OFF = 8'h00;
  localparam logic [7:0] GDSP_PUMP_CFG_OFF   = 8'h04;
  localparam logic [7:0] GDSP_STATUS_OFF     = 8'h08;
  // supply config fields
  localparam int GDSP_VSEL_LSB  = 0;
  localparam int GDSP_PRECH_BIT = 2;
  // pump config fields
  localparam int GDSP_CLKSEL_LSB = 0;
  localparam int GDSP_SSC_BIT    = 2;
  // status fields
  localparam int GDSP_ST_LS_UV   = 0;
  localparam int GDSP_ST_HS_UV   = 1;
  localparam int GDSP_ST_LS_FLT  = 2;
  localparam int GDSP_ST_HS_FLT  = 3;
  localparam int GDSP_ST_PRDONE  = 4;
  // reset values
  localparam logic [1:0] GDSP_VSEL_RST   = 2'h0;
  localparam logic [1:0] GDSP_CLKSEL_RST = 2'h0;
  // drive voltage codes
  localparam logic [1:0] GDSP_V7  = 2'h3;
  localparam logic [1:0] GDSP_V10 = 2'h2;
  localparam logic [1:0] GDSP_V12 = 2'h0;
  localparam logic [1:0] GDSP_V15 = 2'h1;
  // pump clock half periods in system cycles, per select code
  localparam logic [7:0] GDSP_HALF0 = 8'h08;
  localparam logic [7:0] GDSP_HALF1 = 8'h0c;
  localparam logic [7:0] GDSP_HALF2 = 8'h10;
  localparam logic [7:0] GDSP_HALF3 = 8'h14;
  localparam logic [7:0] GDSP_SSC_SPAN = 8'h04;
  // precharge duration
  localparam int GDSP_PRECH_US  = 100;
  localparam int GDSP_CLK_MHZ   = 40;
  localparam int GDSP_PRECH_CYC = GDSP_PRECH_US * GDSP_CLK_MHZ;
  localparam logic [1:0] GDSP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] GDSP_RESP_DECERR = 2'h3;
endpackage

// file: gdsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module gdsp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  input  wire logic [WIDTH-1:0] rst_val,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= rst_val;
      q        <= rst_val;
    end else if (ce) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: gdsp_pump_clk.sv
`timescale 1ns/1ps
`default_nettype none
module gdsp_pump_clk
  import gdsp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [1:0] clk_sel,
  input  wire logic       ssc_en,
  output logic            pump_clk
);
  logic [7:0] half;
  logic [7:0] cnt_reg;
  logic [7:0] dith_reg;
  logic       up_reg;
  always_comb begin
    case (clk_sel)
      2'h0:    half = GDSP_HALF0;
      2'h1:    half = GDSP_HALF1;
      2'h2:    half = GDSP_HALF2;
      default: half = GDSP_HALF3;
    endcase
    // triangle dither keeps each half period within half +/- span
    if (ssc_en) half = 8'(half + dith_reg - GDSP_SSC_SPAN);
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg  <= 8'h00;
      dith_reg <= GDSP_SSC_SPAN;
      up_reg   <= 1'b1;
      pump_clk <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_reg  <= 8'h00;
        pump_clk <= 1'b0;
      end else if (cnt_reg >= 8'(half - 8'h01)) begin
        cnt_reg  <= 8'h00;
        pump_clk <= ~pump_clk;
        // turn one step early so the dither never leaves 0 .. 2*span
        if (pump_clk && ssc_en) begin
          dith_reg <= up_reg ? 8'(dith_reg + 8'h01) : 8'(dith_reg - 8'h01);
          if (up_reg && dith_reg == 8'(GDSP_SSC_SPAN * 2 - 1)) up_reg <= 1'b0;
          else if (!up_reg && dith_reg == 8'h01) up_reg <= 1'b1;
        end
      end else begin
        cnt_reg <= 8'(cnt_reg + 8'h01);
      end
    end
  end
endmodule
`default_nettype wire

// file: gdsp_top.sv
// Function
// - one voltage setpoint drives both pumps
// - codes 11=7V 10=10V 00=12V 01=15V
// - host selects one of four pump clocks
// - spread spectrum varies pump clock in bounds
// - precharge low rail once before driver enable
// - low rail lockout blocks pwm
// - low rail rising threshold releases lockout
// - low rail fall: hi-z outputs, raise fault
// - low rail fault pulls fault_out_n low
// - high rail rising threshold releases lockout
// - high rail fall: hi-z outputs, raise fault
// - high rail fault pulls fault_out_n low
// - weak pull-down always on every output
// - strong pull-down when off and vgs rises
`timescale 1ns/1ps
`default_nettype none
module gdsp_top
  import gdsp_pkg::*;
#(
  parameter int NOUT      = 6,
  parameter int PRECH_CYC = GDSP_PRECH_CYC
) (
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            ce,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic            driver_enable_pin,
  input  wire logic [NOUT-1:0] pwm_in,
  input  wire logic            ls_rail_above_rise,
  input  wire logic            ls_rail_below_fall,
  input  wire logic            hs_rail_above_rise,
  input  wire logic            hs_rail_below_fall,
  input  wire logic            precharge_reached,
  input  wire logic [NOUT-1:0] vgs_high,
  output logic [NOUT-1:0]      gate_out,
  output logic [NOUT-1:0]      gate_hiz,
  output logic [NOUT-1:0]      weak_pd_on,
  output logic [NOUT-1:0]      strong_pd_on,
  output logic [1:0]           drive_voltage_target,
  output logic                 pump_clk_out,
  output logic                 precharge_on,
  output logic                 fault_out_n
);
  if (NOUT < 1 || NOUT > 26) begin : g_bad_nout
    $error("gdsp_top: NOUT out of range");
  end
  if (PRECH_CYC < 1) begin : g_bad_prech
    $error("gdsp_top: PRECH_CYC must be positive");
  end

  typedef enum logic [1:0] {GDSP_PR_IDLE, GDSP_PR_RUN, GDSP_PR_DONE} gdsp_pr_t;

  logic [1:0]  drive_voltage_select_reg;
  logic        pump_precharge_enable_reg;
  logic [1:0]  pump_clock_select_reg;
  logic        ssc_en_reg;
  logic        ls_uv_reg;
  logic        hs_uv_reg;
  logic        ls_flt_reg;
  logic        hs_flt_reg;
  gdsp_pr_t    pr_state_reg;
  logic [31:0] pr_cnt_reg;
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic [3:0]  rail_raw;
  logic [3:0]  rail_s;
  logic        pump_clk_int;
  logic        drv_on;
  logic        do_write;
  logic        do_read;
  logic [31:0] rd_word;
  logic [31:0] status_word;

  assign rail_raw = {hs_rail_below_fall, hs_rail_above_rise, ls_rail_below_fall, ls_rail_above_rise};

  gdsp_sync #(.WIDTH(4)) u_sync (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .d       (rail_raw),
    .rst_val (4'h0),
    .q       (rail_s)
  );

  gdsp_pump_clk u_pclk (
    .clk      (clk),
    .srst     (srst),
    .ce       (ce),
    .run      (driver_enable_pin | (pr_state_reg == GDSP_PR_RUN)),
    .clk_sel  (pump_clock_select_reg),
    .ssc_en   (ssc_en_reg),
    .pump_clk (pump_clk_int)
  );

  // lockouts start asserted; release on rising threshold, set on falling
  always_ff @(posedge clk) begin
    if (srst) begin
      ls_uv_reg <= 1'b1;
      hs_uv_reg <= 1'b1;
    end else if (ce) begin
      if (rail_s[1]) ls_uv_reg <= 1'b1;
      else if (rail_s[0]) ls_uv_reg <= 1'b0;
      if (rail_s[3]) hs_uv_reg <= 1'b1;
      else if (rail_s[2]) hs_uv_reg <= 1'b0;
    end
  end

  // sticky faults: a fall during the clear cycle keeps the flag set
  always_ff @(posedge clk) begin
    if (srst) begin
      ls_flt_reg <= 1'b0;
      hs_flt_reg <= 1'b0;
    end else if (ce) begin
      if (rail_s[1] && !ls_uv_reg) ls_flt_reg <= 1'b1;
      else if (do_write && awaddr_reg == GDSP_STATUS_OFF && wstrb_reg[0] && wdata_reg[GDSP_ST_LS_FLT])
        ls_flt_reg <= 1'b0;
      if (rail_s[3] && !hs_uv_reg) hs_flt_reg <= 1'b1;
      else if (do_write && awaddr_reg == GDSP_STATUS_OFF && wstrb_reg[0] && wdata_reg[GDSP_ST_HS_FLT])
        hs_flt_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) fault_out_n <= 1'b1;
    else if (ce) fault_out_n <= ~(ls_flt_reg | hs_flt_reg);
  end

  // precharge only once per reset; software enable is the host's job
  always_ff @(posedge clk) begin
    if (srst) begin
      pr_state_reg <= GDSP_PR_IDLE;
      pr_cnt_reg   <= 32'h0;
      precharge_on <= 1'b0;
    end else if (ce) begin
      case (pr_state_reg)
        GDSP_PR_IDLE: begin
          if (driver_enable_pin) pr_state_reg <= GDSP_PR_DONE;
          else if (pump_precharge_enable_reg) begin
            pr_state_reg <= GDSP_PR_RUN;
            precharge_on <= 1'b1;
          end
        end
        GDSP_PR_RUN: begin
          pr_cnt_reg <= 32'(pr_cnt_reg + 32'h1);
          if (driver_enable_pin || precharge_reached || pr_cnt_reg >= 32'(PRECH_CYC - 1)) begin
            pr_state_reg <= GDSP_PR_DONE;
            precharge_on <= 1'b0;
          end
        end
        default: precharge_on <= 1'b0;
      endcase
    end
  end

  assign drv_on = driver_enable_pin & ~ls_uv_reg & ~hs_uv_reg;

  genvar gi;
  generate
    for (gi = 0; gi < NOUT; gi++) begin : g_out
      always_ff @(posedge clk) begin
        if (srst) begin
          gate_out[gi]     <= 1'b0;
          gate_hiz[gi]     <= 1'b1;
          weak_pd_on[gi]   <= 1'b1;
          strong_pd_on[gi] <= 1'b0;
        end else if (ce) begin
          gate_out[gi]     <= drv_on & pwm_in[gi];
          gate_hiz[gi]     <= ~drv_on;
          weak_pd_on[gi]   <= 1'b1;
          strong_pd_on[gi] <= ~drv_on & vgs_high[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (srst) begin
      drive_voltage_target <= GDSP_VSEL_RST;
      pump_clk_out         <= 1'b0;
    end else if (ce) begin
      drive_voltage_target <= drive_voltage_select_reg;
      pump_clk_out         <= pump_clk_int;
    end
  end

  // axi4-lite write: address and data captured independently
  assign do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= GDSP_RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= ~aw_hold_reg & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_hold_reg & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_reg == GDSP_SUPPLY_CFG_OFF || awaddr_reg == GDSP_PUMP_CFG_OFF ||
            awaddr_reg == GDSP_STATUS_OFF) s_axi_bresp <= GDSP_RESP_OKAY;
        else s_axi_bresp <= GDSP_RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      drive_voltage_select_reg  <= GDSP_VSEL_RST;
      pump_precharge_enable_reg <= 1'b0;
      pump_clock_select_reg     <= GDSP_CLKSEL_RST;
      ssc_en_reg                <= 1'b0;
    end else if (ce && do_write && wstrb_reg[0]) begin
      if (awaddr_reg == GDSP_SUPPLY_CFG_OFF) begin
        drive_voltage_select_reg  <= wdata_reg[GDSP_VSEL_LSB +: 2];
        pump_precharge_enable_reg <= wdata_reg[GDSP_PRECH_BIT];
      end else if (awaddr_reg == GDSP_PUMP_CFG_OFF) begin
        pump_clock_select_reg <= wdata_reg[GDSP_CLKSEL_LSB +: 2];
        ssc_en_reg            <= wdata_reg[GDSP_SSC_BIT];
      end
    end
  end

  // axi4-lite read
  assign do_read = s_axi_arvalid & s_axi_arready;

  always_comb begin
    status_word = 32'h0;
    status_word[GDSP_ST_LS_UV]  = ls_uv_reg;
    status_word[GDSP_ST_HS_UV]  = hs_uv_reg;
    status_word[GDSP_ST_LS_FLT] = ls_flt_reg;
    status_word[GDSP_ST_HS_FLT] = hs_flt_reg;
    status_word[GDSP_ST_PRDONE] = (pr_state_reg == GDSP_PR_DONE);
    rd_word = 32'h0;
    if (s_axi_araddr == GDSP_SUPPLY_CFG_OFF) begin
      rd_word[GDSP_VSEL_LSB +: 2] = drive_voltage_select_reg;
      rd_word[GDSP_PRECH_BIT]     = pump_precharge_enable_reg;
    end else if (s_axi_araddr == GDSP_PUMP_CFG_OFF) begin
      rd_word[GDSP_CLKSEL_LSB +: 2] = pump_clock_select_reg;
      rd_word[GDSP_SSC_BIT]         = ssc_en_reg;
    end else if (s_axi_araddr == GDSP_STATUS_OFF) begin
      rd_word = status_word;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= GDSP_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (do_read) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        if (s_axi_araddr == GDSP_SUPPLY_CFG_OFF || s_axi_araddr == GDSP_PUMP_CFG_OFF ||
            s_axi_araddr == GDSP_STATUS_OFF) s_axi_rresp <= GDSP_RESP_OKAY;
        else s_axi_rresp <= GDSP_RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: gdsp_pwm_host.sv
`timescale 1ns/1ps
`default_nettype none
module gdsp_pwm_host #(
  parameter int NOUT = 6
) (
  input  wire logic            clk,
  input  wire logic            srst,
  output logic      [NOUT-1:0] pwm
);
  // counting pattern changes every cycle, so a stale or stuck gate output never matches by luck
  always_ff @(posedge clk) begin
    if (srst) begin
      pwm <= '0;
    end else begin
      pwm <= pwm + NOUT'(1);
    end
  end
endmodule
`default_nettype wire

// file: gdsp_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module gdsp_top_props #(
  parameter int NOUT = 6
) (
  input wire logic            clk,
  input wire logic            srst,
  input wire logic            driver_enable_pin,
  input wire logic [NOUT-1:0] pwm_in,
  input wire logic            ls_rail_above_rise,
  input wire logic            ls_rail_below_fall,
  input wire logic            hs_rail_above_rise,
  input wire logic            hs_rail_below_fall,
  input wire logic [NOUT-1:0] vgs_high,
  input wire logic [NOUT-1:0] gate_out,
  input wire logic [NOUT-1:0] gate_hiz,
  input wire logic [NOUT-1:0] weak_pd_on,
  input wire logic [NOUT-1:0] strong_pd_on,
  input wire logic            pump_clk_out,
  input wire logic            precharge_on,
  input wire logic            fault_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire logic rails_ok = ls_rail_above_rise && !ls_rail_below_fall && hs_rail_above_rise && !hs_rail_below_fall;
  a_weak_always: assert property (weak_pd_on == '1)
    else $error("weak pull-down off");
  a_hiz_no_pwm: assert property ((gate_out & gate_hiz) == '0)
    else $error("pwm on a hi-z gate");
  a_pwm_passes: assert property (gate_hiz == '0 |-> gate_out == $past(pwm_in))
    else $error("pwm not passed");
  a_strong_pd: assert property (strong_pd_on == (gate_hiz & $past(vgs_high)))
    else $error("strong pull-down wrong");
  a_ls_fall_hiz: assert property ($rose(ls_rail_below_fall) |-> ##[1:5] gate_hiz == '1)
    else $error("low rail fall not hi-z");
  a_hs_fall_hiz: assert property ($rose(hs_rail_below_fall) |-> ##[1:5] gate_hiz == '1)
    else $error("high rail fall not hi-z");
  a_ls_fault_pin: assert property ($rose(ls_rail_below_fall) && gate_hiz == '0 |-> ##[1:6] !fault_out_n)
    else $error("low rail fault pin high");
  a_hs_fault_pin: assert property ($rose(hs_rail_below_fall) && gate_hiz == '0 |-> ##[1:6] !fault_out_n)
    else $error("high rail fault pin high");
  a_rails_release: assert property ((driver_enable_pin && rails_ok) [*8] |-> gate_hiz == '0)
    else $error("lockout not released");
  a_pump_idle: assert property ((!driver_enable_pin && !precharge_on) [*4] |-> !pump_clk_out)
    else $error("pump clock runs idle");
  c_precharge: cover property (precharge_on);
  c_fault: cover property (!fault_out_n);
  c_driving: cover property (gate_hiz == '0);
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import gdsp_pkg::*;
;
  localparam int NOUT = 6;
  logic        clk = 1'h0;
  logic        srst = 1'h1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, pclk, prech_on, flt_n;
  logic [1:0]  bresp, rresp, target;
  logic        en = 1'h0, prech_hit = 1'h0, ce = 1'h1;
  logic [3:0]  rail = 4'h0, strb = 4'hf;
  logic [5:0]  pwm, gout, hiz, wpd, spd, vgs = 6'h00;
  int          errors = 0, n_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  gdsp_pwm_host #(.NOUT(NOUT)) u_gdsp_pwm_host (.clk(clk), .srst(srst), .pwm(pwm));
  gdsp_top #(.NOUT(NOUT), .PRECH_CYC(20)) u_gdsp_top (.clk(clk), .srst(srst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .driver_enable_pin(en), .pwm_in(pwm), .ls_rail_above_rise(rail[0]),
    .ls_rail_below_fall(rail[1]), .hs_rail_above_rise(rail[2]), .hs_rail_below_fall(rail[3]),
    .precharge_reached(prech_hit), .vgs_high(vgs), .gate_out(gout), .gate_hiz(hiz), .weak_pd_on(wpd),
    .strong_pd_on(spd), .drive_voltage_target(target), .pump_clk_out(pclk), .precharge_on(prech_on),
    .fault_out_n(flt_n));
  task automatic stop_test();
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // address and data offered together; each released on its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge clk);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 1'h0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 1'h0;
      end
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar;
    ar = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge clk);
      if (!ar && arready) begin
        ar = 1;
        arvalid <= 1'h0;
      end
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  task automatic wait_on(input logic v);
    for (int n = 0; n < 60 && prech_on !== v; n++) @(posedge clk);
  endtask
  task automatic half(output int h);
    logic p;
    p = pclk;
    h = 0;
    do begin
      @(posedge clk);
      h++;
    end while (pclk === p && h < 200);
  endtask
  // must run first: precharge only happens while the driver is still disabled
  task automatic t_precharge();
    logic [1:0] r;
    logic [31:0] d;
    wr(GDSP_SUPPLY_CFG_OFF, 32'h4, r);
    wait_on(1'h1);
    chk("prech_on", 1, prech_on);
    prech_hit <= 1'h1;
    wait_on(1'h0);
    rd(GDSP_STATUS_OFF, d, r);
    chk("prech_done", 1, d[GDSP_ST_PRDONE]);
    prech_hit <= 1'h0;
    tick(30);
    chk("prech_again", 0, prech_on);
  endtask
  task automatic t_setpoint();
    logic [1:0] codes[4] = '{GDSP_V7, GDSP_V10, GDSP_V12, GDSP_V15};
    logic [1:0] r;
    logic [31:0] d;
    foreach (codes[i]) begin
      wr(GDSP_SUPPLY_CFG_OFF, {30'h0, codes[i]}, r);
      tick(2);
      chk("target", codes[i], target);
      rd(GDSP_SUPPLY_CFG_OFF, d, r);
      chk("vsel_rd", codes[i], d[1:0]);
    end
    strb <= 4'h0;
    wr(GDSP_SUPPLY_CFG_OFF, 32'h3, r);
    chk("wr_strb_resp", GDSP_RESP_OKAY, r);
    strb <= 4'hf;
    rd(GDSP_SUPPLY_CFG_OFF, d, r);
    chk("strb_ignored", GDSP_V15, d[1:0]);
    wr(8'h0c, 32'h1, r);
    chk("wr_unmapped", GDSP_RESP_DECERR, r);
    rd(8'h0c, d, r);
    chk("rd_unmapped", GDSP_RESP_DECERR, r);
    chk("rd_unmapped_data", 0, d);
  endtask
  task automatic t_pump();
    logic [7:0] hf[4] = '{GDSP_HALF0, GDSP_HALF1, GDSP_HALF2, GDSP_HALF3};
    logic [1:0] r;
    int h, lo, hi;
    en <= 1'h1;
    for (int s = 0; s < 5; s++) begin
      wr(GDSP_PUMP_CFG_OFF, (s == 4) ? 32'h4 : 32'(s), r);
      lo = 999;
      hi = 0;
      half(h);
      half(h);
      repeat (12) begin
        half(h);
        lo = (h < lo) ? h : lo;
        hi = (h > hi) ? h : hi;
      end
      if (s < 4) begin
        chk("pump_lo", hf[s], lo);
        chk("pump_hi", hf[s], hi);
      end else begin
        chk("ssc_varies", 1, lo < hi);
        chk("ssc_bounds", 1, lo >= GDSP_HALF0 - GDSP_SSC_SPAN && hi <= GDSP_HALF0 + GDSP_SSC_SPAN);
      end
    end
  endtask
  task automatic t_uvlo();
    logic [1:0] r;
    logic [31:0] d;
    logic [5:0] pv;
    for (int k = 0; k < 2; k++) begin
      rail <= 4'h5;
      tick(10);
      chk("hiz_released", 0, hiz);
      pv = pwm;
      @(posedge clk);
      chk("gate_out", pv, gout);
      rail <= k ? 4'h9 : 4'h6;
      tick(7);
      chk("hiz_on_fall", 6'h3f, hiz);
      chk("fault_pin", 0, flt_n);
      rd(GDSP_STATUS_OFF, d, r);
      chk("status", (1 << k) | (4 << k) | 16, d[4:0]);
      rail <= 4'h5;
      tick(6);
      wr(GDSP_STATUS_OFF, 32'(4 << k), r);
      tick(3);
      chk("fault_clear", 1, flt_n);
    end
  endtask
  task automatic t_pulldown();
    en <= 1'h0;
    vgs <= 6'h2a;
    tick(4);
    chk("strong_off", 6'h2a, spd);
    chk("weak_off", 6'h3f, wpd);
    ce <= 1'h0;
    en <= 1'h1;
    tick(4);
    chk("strong_frozen", 6'h2a, spd);
    chk("hiz_frozen", 6'h3f, hiz);
    ce <= 1'h1;
    tick(10);
    chk("strong_on", 0, spd);
    chk("weak_on", 6'h3f, wpd);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    tick(6);
    srst <= 1'h0;
    t_precharge();
    t_setpoint();
    t_pump();
    t_uvlo();
    t_pulldown();
    stop_test();
  end
endmodule
bind gdsp_top gdsp_top_props #(.NOUT(NOUT)) u_gdsp_top_props (.clk, .srst, .driver_enable_pin, .pwm_in,
  .ls_rail_above_rise, .ls_rail_below_fall, .hs_rail_above_rise, .hs_rail_below_fall, .vgs_high, .gate_out,
  .gate_hiz, .weak_pd_on, .strong_pd_on, .pump_clk_out, .precharge_on, .fault_out_n);
`default_nettype wire
